// ===== logic/qcc_cfg.svh
/*
 * Offsets, field positions, write mask and reset values of the quadrature
 * counter control block. Assumes inclusion by bare name from logic/.
 */
`ifndef QCC_CFG_SVH
`define QCC_CFG_SVH

// ==========================================================================
// register offsets
// ==========================================================================
`define QCC_ADDR_CONTROL 4'h0
`define QCC_ADDR_GEC 4'h1
`define QCC_ADDR_INIT 4'h2
`define QCC_ADDR_POSITION 4'h3
`define QCC_ADDR_MISC 4'h4

// ==========================================================================
// control field positions
// ==========================================================================
`define QCC_BIT_ENABLE 15
`define QCC_BIT_IDLE_STOP 13
`define QCC_MODE_HI 12
`define QCC_MODE_LO 10
`define QCC_BIT_MATCH_B 9
`define QCC_BIT_MATCH_A 8
`define QCC_CTRL_WMASK 16'hBF7F

// ==========================================================================
// reset values
// ==========================================================================
`define QCC_CTRL_RESET 16'h0000
`define QCC_POS_RESET 32'h0000_0000

`endif

// ===== logic/qcc_pkg.sv
/*
 * Types of the quadrature counter control block.
 * Assumes qcc_cfg.svh supplies the numbers.
 */
package qcc_pkg;

	typedef enum logic [2:0] {
		QCC_MODE_NONE = 3'h0,
		QCC_MODE_IDX_RESET = 3'h1,
		QCC_MODE_IDX_LOAD = 3'h2,
		QCC_MODE_HOME_IDX1 = 3'h3,
		QCC_MODE_HOME_IDX2 = 3'h4,
		QCC_MODE_GEC_RESET = 3'h5,
		QCC_MODE_MODULO = 3'h6,
		QCC_MODE_RESERVED = 3'h7
	} qcc_mode_t;

	typedef struct packed {
		logic enable;
		logic idle_stop;
		qcc_mode_t mode;
		logic match_b;
		logic match_a;
	} qcc_ctrl_t;

	typedef struct packed {
		logic phase_a;
		logic phase_b;
		logic index;
		logic home;
	} qcc_pins_t;

endpackage

// ===== logic/qcc_counter.sv
/*
 * Quadrature counter control: control register, position counter and
 * index/home driven initialization.
 * Assumes encoder inputs are synchronous to CLK_SYS_IN and a plain
 * register port with read data one cycle after the read strobe.
 */
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "qcc_cfg.svh"

module qcc_counter #(
	parameter int POS_WIDTH = 32
) (
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	input wire logic [3:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic IDLE_IN,
	input wire logic PHASE_A_IN,
	input wire logic PHASE_B_IN,
	input wire logic INDEX_IN,
	input wire logic HOME_IN,
	output logic [31:0] RDATA_OUT,
	output logic RUNNING_OUT,
	output logic INDEX_EVENT_OUT
);

	// refused at elaboration: the read mux and the cast to 32 bits need 2..32
	generate
		if (POS_WIDTH < 2 || POS_WIDTH > 32)
		begin
			$error("POS_WIDTH must be 2..32");
		end
	endgenerate

	// ======================================================================
	// register file
	// ======================================================================
	logic [15:0] ctrl_reg;
	logic [7:0] misc_reg;
	logic [POS_WIDTH-1:0] gec_reg;
	logic [POS_WIDTH-1:0] init_reg;
	logic [POS_WIDTH-1:0] pos_reg;
	logic [POS_WIDTH-1:0] pos_next;
	qcc_pkg::qcc_ctrl_t ctrl;
	logic pos_wr;

	assign ctrl.enable = ctrl_reg[`QCC_BIT_ENABLE];
	assign ctrl.idle_stop = ctrl_reg[`QCC_BIT_IDLE_STOP];
	assign ctrl.mode = qcc_pkg::qcc_mode_t'(ctrl_reg[`QCC_MODE_HI:`QCC_MODE_LO]);
	assign ctrl.match_b = ctrl_reg[`QCC_BIT_MATCH_B];
	assign ctrl.match_a = ctrl_reg[`QCC_BIT_MATCH_A];
	assign pos_wr = WR_IN && (ADDR_IN == `QCC_ADDR_POSITION);

	always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			ctrl_reg <= `QCC_CTRL_RESET;
			misc_reg <= 8'h00;
			gec_reg <= '0;
			init_reg <= '0;
		end
		else if (WR_IN)
		begin
			unique case (ADDR_IN)
				// unimplemented bits never store
				`QCC_ADDR_CONTROL: ctrl_reg <= WDATA_IN[15:0] & `QCC_CTRL_WMASK;
				`QCC_ADDR_GEC: gec_reg <= WDATA_IN[POS_WIDTH-1:0];
				`QCC_ADDR_INIT: init_reg <= WDATA_IN[POS_WIDTH-1:0];
				// low byte bits 6:0 kept as plain storage, bit 7 absent
				`QCC_ADDR_MISC: misc_reg <= {1'b0, WDATA_IN[6:0]};
				default: ;
			endcase
		end
	end

	// readable whether or not the counter runs
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
	begin
		if (RST_IN)
			RDATA_OUT <= 32'h0000_0000;
		else if (RD_IN)
		begin
			unique case (ADDR_IN)
				`QCC_ADDR_CONTROL: RDATA_OUT <= {16'h0000, ctrl_reg[15:8], misc_reg};
				`QCC_ADDR_GEC: RDATA_OUT <= 32'(gec_reg);
				`QCC_ADDR_INIT: RDATA_OUT <= 32'(init_reg);
				`QCC_ADDR_POSITION: RDATA_OUT <= 32'(pos_reg);
				default: RDATA_OUT <= 32'h0000_0000;
			endcase
		end
		else
			RDATA_OUT <= 32'h0000_0000;
	end

	// ======================================================================
	// run gating
	// ======================================================================
	logic run;

	// idle stop only matters while the device is idle
	assign run = ctrl.enable && !(ctrl.idle_stop && IDLE_IN);

	// ======================================================================
	// event capture: one registered stage gives single-cycle pulses
	// ======================================================================
	qcc_pkg::qcc_pins_t pins_reg;
	logic index_match;
	logic index_evt;
	logic home_evt;

	always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
	begin
		if (RST_IN)
			pins_reg <= '0;
		else
			pins_reg <= '{PHASE_A_IN, PHASE_B_IN, INDEX_IN, HOME_IN};
	end

	// match needs both phase levels as programmed
	assign index_match = (PHASE_B_IN == ctrl.match_b) && (PHASE_A_IN == ctrl.match_a);
	// rising edges, each lasting exactly one cycle
	assign index_evt = INDEX_IN && !pins_reg.index && index_match;
	assign home_evt = HOME_IN && !pins_reg.home;

	// ======================================================================
	// home arming for modes 011 and 100
	// ======================================================================
	logic armed_reg;
	logic seen_reg;

	always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			armed_reg <= 1'b0;
			seen_reg <= 1'b0;
		end
		else if (run)
		begin
			if (home_evt)
			begin
				armed_reg <= 1'b1;
				seen_reg <= 1'b0;
			end
			else if (armed_reg && index_evt)
			begin
				// second index disarms in mode 100 first in 011
				if (ctrl.mode == qcc_pkg::QCC_MODE_HOME_IDX2 && !seen_reg)
					seen_reg <= 1'b1;
				else
					armed_reg <= 1'b0;
			end
		end
	end

	// ======================================================================
	// position counter
	// ======================================================================
	logic dir_up;
	logic step;
	logic [POS_WIDTH-1:0] counted;

	// x2 decode on both phase A edges, direction from phase A xor phase B
	assign step = PHASE_A_IN != pins_reg.phase_a;
	assign dir_up = PHASE_A_IN ^ PHASE_B_IN;

	always_comb
	begin
		counted = pos_reg;
		if (step)
		begin
			if (dir_up)
			begin
				// wraps at the compare value in modulo mode
				if (ctrl.mode == qcc_pkg::QCC_MODE_MODULO && pos_reg == gec_reg)
					counted = '0;
				else
					counted = pos_reg + 1'b1;
			end
			else
			begin
				if (ctrl.mode == qcc_pkg::QCC_MODE_MODULO && pos_reg == '0)
					counted = gec_reg;
				else
					counted = pos_reg - 1'b1;
			end
		end
		pos_next = counted;
		unique case (ctrl.mode)
			qcc_pkg::QCC_MODE_NONE: ; // index leaves counter alone
			qcc_pkg::QCC_MODE_IDX_RESET:
				if (index_evt)
					pos_next = '0;
			qcc_pkg::QCC_MODE_IDX_LOAD:
				if (index_evt)
					pos_next = init_reg;
			qcc_pkg::QCC_MODE_HOME_IDX1:
				if (index_evt && armed_reg)
					pos_next = init_reg;
			qcc_pkg::QCC_MODE_HOME_IDX2:
				if (index_evt && armed_reg && seen_reg)
					pos_next = init_reg;
			qcc_pkg::QCC_MODE_GEC_RESET:
				if (pos_reg == gec_reg)
					pos_next = '0;
			qcc_pkg::QCC_MODE_MODULO: ;
			// software must not use 111; treated as no index action
			qcc_pkg::QCC_MODE_RESERVED: ;
		endcase
	end

	always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
	begin
		if (RST_IN)
			pos_reg <= `QCC_POS_RESET;
		else if (pos_wr)
			pos_reg <= WDATA_IN[POS_WIDTH-1:0];
		else if (run)
			pos_reg <= pos_next;
	end

	always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			RUNNING_OUT <= 1'b0;
			INDEX_EVENT_OUT <= 1'b0;
		end
		else
		begin
			RUNNING_OUT <= run;
			INDEX_EVENT_OUT <= run && index_evt;
		end
	end

	// ======================================================================
	// assertions
	// ======================================================================
	default clocking cb @(posedge CLK_SYS_IN);
	endclocking
	default disable iff (RST_IN);

	sequence s_index_seen;
		run && index_evt && !pos_wr;
	endsequence

	a_halt_holds_pos: assert property (!run && !pos_wr |=> $stable(pos_reg))
		else $error("position changed while halted");
	a_ctrl_unimpl_zero: assert property (ctrl_reg[14] == 1'b0 && misc_reg[7] == 1'b0)
		else $error("unimplemented control bit set");
	a_idle_stop_halts: assert property (ctrl.idle_stop && IDLE_IN |=> !RUNNING_OUT)
		else $error("running while idle stop active");
	a_idle_keep_runs: assert property (ctrl.enable && !ctrl.idle_stop |=> RUNNING_OUT)
		else $error("not running while enabled");
	a_gec_reset_zero: assert property (run && !pos_wr
		&& ctrl.mode == qcc_pkg::QCC_MODE_GEC_RESET && pos_reg == gec_reg |=> pos_reg == '0)
		else $error("compare reset missed");
	a_idx_reset_zero: assert property (s_index_seen
		and ctrl.mode == qcc_pkg::QCC_MODE_IDX_RESET |=> pos_reg == '0)
		else $error("index reset missed");
	a_idx_load_init: assert property (s_index_seen
		and ctrl.mode == qcc_pkg::QCC_MODE_IDX_LOAD |=> pos_reg == $past(init_reg))
		else $error("index load missed");
	a_home_first_load: assert property (s_index_seen and armed_reg
		and ctrl.mode == qcc_pkg::QCC_MODE_HOME_IDX1 |=> pos_reg == $past(init_reg))
		else $error("first index after home did not load");
	a_home_second_arm: assert property (s_index_seen and armed_reg and !seen_reg and !home_evt
		and ctrl.mode == qcc_pkg::QCC_MODE_HOME_IDX2 |=> seen_reg && armed_reg)
		else $error("first index after home not counted");
	a_match_gates_idx: assert property (index_evt |-> PHASE_A_IN == ctrl.match_a
		&& PHASE_B_IN == ctrl.match_b)
		else $error("index event without phase match");
	a_event_one_cycle: assert property (index_evt |=> !index_evt)
		else $error("index event longer than one cycle");
	a_none_keeps_pos: assert property (s_index_seen and !step
		and ctrl.mode == qcc_pkg::QCC_MODE_NONE |=> $stable(pos_reg))
		else $error("index event moved counter in mode 000");
	a_home_second_load: assert property (s_index_seen and armed_reg and seen_reg
		and ctrl.mode == qcc_pkg::QCC_MODE_HOME_IDX2 |=> pos_reg == $past(init_reg))
		else $error("second index after home did not load");
	a_modulo_wrap: assert property (run && !pos_wr && step && dir_up
		&& ctrl.mode == qcc_pkg::QCC_MODE_MODULO && pos_reg == gec_reg |=> pos_reg == '0)
		else $error("modulo wrap missed");
	a_read_idle_zero: assert property (!RD_IN |=> RDATA_OUT == 32'h0000_0000)
		else $error("read data stood without a read");

endmodule
`default_nettype wire

// ===== tb/qcc_encoder_model.sv
/*
 * Incremental encoder model: two phases, index and home, as one pin struct.
 * Assumes the bench calls its tasks from one process, off the clock edge.
 */
`timescale 1ns/10ps
`default_nettype none
module qcc_encoder_model (
	input wire logic clk_in,
	output var qcc_pkg::qcc_pins_t pins_out
);
	// ==========================================================
	// encoder motion
	// ==========================================================
	initial pins_out = '0;

	// phase b moves first, so only the phase a edge counts and sets direction
	task automatic step(input logic up);
		@(posedge clk_in);
		pins_out.phase_b <= ~pins_out.phase_a ^ up;
		@(posedge clk_in);
		pins_out.phase_a <= ~pins_out.phase_a;
	endtask

	task automatic phases(input logic a, input logic b);
		@(posedge clk_in);
		pins_out.phase_a <= a;
		pins_out.phase_b <= b;
	endtask

	// index or home held high two cycles, one rising edge per call
	task automatic pulse(input logic home);
		@(posedge clk_in);
		if (home)
			pins_out.home <= 1'b1;
		else
			pins_out.index <= 1'b1;
		repeat (2) @(posedge clk_in);
		pins_out.home <= 1'b0;
		pins_out.index <= 1'b0;
		@(posedge clk_in);
	endtask
endmodule
`default_nettype wire

// ===== tb/qcc_counter_bench.sv
/*
 * Self-checking bench of the quadrature counter control block.
 * Assumes qcc_pkg is compiled first and the encoder model sits beside it.
 */
`timescale 1ns/10ps
`default_nettype none
module qcc_counter_bench;
	logic clk, rst, wr, rd, idle;
	logic [3:0] addr;
	logic [31:0] wdata;
	wire [31:0] rdata;
	wire running, ievt;
	qcc_pkg::qcc_pins_t pins;
	int bad_count, cmp_count, evt_n;

	qcc_encoder_model enc (.clk_in(clk), .pins_out(pins));
	qcc_counter dut (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .IDLE_IN(idle), .PHASE_A_IN(pins.phase_a),
		.PHASE_B_IN(pins.phase_b), .INDEX_IN(pins.index), .HOME_IN(pins.home),
		.RDATA_OUT(rdata), .RUNNING_OUT(running), .INDEX_EVENT_OUT(ievt));

	// ==========================================================
	// bus and compare tasks
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	task automatic chk_run(input logic exp);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, running}, {31'h0, exp});
	endtask

	task automatic mode(input logic [2:0] m, input logic [1:0] ba);
		wr_reg(4'h0, {16'h0, 1'b1, 2'b00, m, ba, 8'h00});
	endtask

	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic t_fields();
		chk_reg(4'h0, 32'h0000_0000);
		wr_reg(4'h1, 32'hA5A5_5A5A);
		wr_reg(4'h2, 32'hFFFF_FFFF);
		wr_reg(4'h3, 32'h5A5A_A5A5);
		wr_reg(4'h9, 32'hFFFF_FFFF);
		chk_reg(4'h1, 32'hA5A5_5A5A);
		chk_reg(4'h2, 32'hFFFF_FFFF);
		chk_reg(4'h3, 32'h5A5A_A5A5);
		chk_reg(4'h9, 32'h0000_0000);
		chk_reg(4'h4, 32'h0000_0000);
		chk_reg(4'h0, 32'h0000_0000);
		// read data must fall back to zero one cycle later
		@(posedge clk);
		#1 chk(rdata, 32'h0000_0000);
		wr_reg(4'h0, 32'h0000_FFFF);
		wr_reg(4'h4, 32'h0000_00FF);
		chk_reg(4'h0, 32'h0000_BF7F);
		wr_reg(4'h4, 32'h0000_0000);
	endtask

	task automatic t_enable();
		mode(3'h0, 2'b00);
		wr_reg(4'h3, 32'h0000_0000);
		chk_run(1'b1);
		repeat (3) enc.step(1'b1);
		enc.step(1'b0);
		chk_reg(4'h3, 32'h0000_0002);
		wr_reg(4'h0, 32'h0000_0000);
		enc.step(1'b1);
		chk_reg(4'h3, 32'h0000_0002);
		chk_run(1'b0);
	endtask

	task automatic t_idle();
		wr_reg(4'h0, 32'h0000_A000);
		idle <= 1'b1;
		chk_run(1'b0);
		enc.step(1'b1);
		chk_reg(4'h3, 32'h0000_0002);
		wr_reg(4'h0, 32'h0000_8000);
		chk_run(1'b1);
		idle <= 1'b0;
	endtask

	task automatic t_index_modes();
		wr_reg(4'h2, 32'h0000_1234);
		enc.phases(1'b0, 1'b0);
		mode(3'h0, 2'b00);
		wr_reg(4'h3, 32'h0000_0005);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_0005);
		mode(3'h7, 2'b00);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_0005);
		mode(3'h1, 2'b00);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_0000);
		mode(3'h2, 2'b00);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_1234);
		mode(3'h3, 2'b00);
		wr_reg(4'h3, 32'h0000_0005);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_0005);
		enc.pulse(1'b1);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_1234);
		mode(3'h4, 2'b00);
		wr_reg(4'h3, 32'h0000_0005);
		enc.pulse(1'b1);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_0005);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_1234);
	endtask

	task automatic t_compare();
		mode(3'h5, 2'b00);
		wr_reg(4'h1, 32'h0000_0002);
		wr_reg(4'h3, 32'h0000_0000);
		repeat (2) enc.step(1'b1);
		// the reset follows one cycle after the counter reaches the compare value
		@(posedge clk);
		chk_reg(4'h3, 32'h0000_0000);
		mode(3'h6, 2'b00);
		wr_reg(4'h1, 32'h0000_0003);
		wr_reg(4'h3, 32'h0000_0003);
		enc.step(1'b1);
		chk_reg(4'h3, 32'h0000_0000);
		enc.step(1'b0);
		chk_reg(4'h3, 32'h0000_0003);
	endtask

	// phase a is tried at both levels against its match bit, phase b only at its match level
	task automatic t_match();
		mode(3'h1, 2'b01);
		enc.phases(1'b0, 1'b0);
		wr_reg(4'h3, 32'h0000_0007);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_0007);
		enc.phases(1'b1, 1'b0);
		wr_reg(4'h3, 32'h0000_0007);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_0000);
		mode(3'h1, 2'b10);
		enc.phases(1'b1, 1'b1);
		wr_reg(4'h3, 32'h0000_0007);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_0007);
		enc.phases(1'b0, 1'b1);
		wr_reg(4'h3, 32'h0000_0007);
		enc.pulse(1'b0);
		chk_reg(4'h3, 32'h0000_0000);
		chk(evt_n, 32'd10);
	endtask

	// ==========================================================
	// clock, reset, run and verdict
	// ==========================================================
	task automatic report_and_stop();
		if (bad_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(negedge clk)
		if (ievt === 1'b1)
			evt_n++;

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial
	begin
		#200000;
		bad_count++;
		report_and_stop();
	end

	initial
	begin
		{rst, wr, rd, idle, addr, wdata} = {1'b1, 39'h0};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_fields();
		t_enable();
		t_idle();
		t_index_modes();
		t_compare();
		t_match();
		report_and_stop();
	end
endmodule
`default_nettype wire
